//--- pfr_cfg.svh
`ifndef PFR_CFG_SVH
`define PFR_CFG_SVH
// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define PFR_CLK_MHZ 40
`define PFR_TICK_US 1000
`define PFR_TICK_CYC (`PFR_CLK_MHZ * `PFR_TICK_US)
`define PFR_FILT_CYC 4
// ----------------------------------------------------------------
// timing in milliseconds, and the overvoltage try count
// ----------------------------------------------------------------
`define PFR_GRACE_MS 20000
`define PFR_OC_DELAY_MS 3000
`define PFR_RETRY_MS 1000
`define PFR_OV_WIN_MS 60000
`define PFR_HOLD_MS 2000
`define PFR_AC_DELAY_MS 10000
`define PFR_STBY_LEAD_MS 450
`define PFR_HICCUP_MS 1000
`define PFR_BLINK_MS 500
`define PFR_OV_TRIES 2'h3
// ----------------------------------------------------------------
// thresholds, 10 mV per count for output and input, 1 mV for vprog
// ----------------------------------------------------------------
`define PFR_V_SHORT 16'h01f4
`define PFR_V_DEFAULT 16'h08fc
`define PFR_V_BLINK 16'h0bb8
`define PFR_V_MAX 16'h1964
`define PFR_VIN_LOW 16'h1f40
`define PFR_VPROG_MIN 16'h0064
`define PFR_VPROG_NUM 20'h0000d
`define PFR_VPROG_DEN 20'h00006
// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define PFR_CMD_VOUT 8'h21
`define PFR_OFS_OPERATION 8'h04
`define PFR_OFS_FAULT_CFG 8'h08
`define PFR_OFS_STATUS 8'h40
`define PFR_OFS_ALARM 8'h44
`define PFR_OFS_STATUS2 8'h48
`define PFR_OFS_SETPOINT 8'h4c
`define PFR_OFS_VOUT_CMD 8'h84
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PFR_CFG_OC 0
`define PFR_CFG_OT 1
`define PFR_ALM_OC 0
`define PFR_ALM_OT 1
`define PFR_ALM_OV 2
`define PFR_ALM_SHORT 3
`define PFR_ALM_ILK 4
`define PFR_ST2_RESTART 0
`define PFR_RST_OP_ON 1'b1
`define PFR_RST_FCFG 2'h0
`endif

//--- pfr_pkg.sv
package pfr_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_RUN, ST_RETRY, ST_HICCUP, ST_LATCH, ST_HOLD
  } pfr_state_e;
  typedef logic [15:0] pfr_ms_t;
  typedef logic [15:0] pfr_volt_t;
  typedef logic [4:0] pfr_alarm_t;
endpackage

//--- pfr_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pfr_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface
`default_nettype wire

//--- pfr_tick.sv
`timescale 1ns/1ps
`default_nettype none
module pfr_tick import pfr_pkg::*; #(
  parameter int TICK_CYC = 40000
) (
  input wire logic mclk,
  input wire logic nrst,
  pfr_tick_if.src tk
);
  if (TICK_CYC < 2 || TICK_CYC > 65536) begin : g_bad
    $error("pfr_tick: TICK_CYC out of range");
  end
  logic [15:0] cnt_reg;
  logic tick_reg;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (cnt_reg == 16'(TICK_CYC - 1)) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end
  assign tk.tick = tick_reg;
endmodule // pfr_tick
`default_nettype wire

//--- pfr_pin_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pfr_pin_filter import pfr_pkg::*; #(
  parameter int N = 7,
  parameter int FILT = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [N-1:0] pin_raw,
  output logic [N-1:0] pin_clean
);
  if (FILT < 1 || FILT > 255) begin : g_bad
    $error("pfr_pin_filter: FILT out of range");
  end
  for (genvar i = 0; i < N; i++) begin : g_pin
    logic s1_reg;
    logic s2_reg;
    logic out_reg;
    logic [7:0] cnt_reg;
    // two-stage synchroniser; only s2 is looked at
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
      end else begin
        s1_reg <= pin_raw[i];
        s2_reg <= s1_reg;
      end
    end
    // a level must differ for FILT cycles in a row before it is taken
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        out_reg <= 1'b0;
        cnt_reg <= 8'h00;
      end else if (s2_reg == out_reg) begin
        cnt_reg <= 8'h00;
      end else if (cnt_reg == 8'(FILT - 1)) begin
        out_reg <= s2_reg;
        cnt_reg <= 8'h00;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
    assign pin_clean[i] = out_reg;
  end
endmodule // pfr_pin_filter
`default_nettype wire

//--- pfr_top.sv
`include "pfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pfr_top import pfr_pkg::*; #(
  parameter int TICK_CYC = `PFR_TICK_CYC,
  parameter int GRACE_MS = `PFR_GRACE_MS,
  parameter int OC_DELAY_MS = `PFR_OC_DELAY_MS,
  parameter int RETRY_MS = `PFR_RETRY_MS,
  parameter int OV_WIN_MS = `PFR_OV_WIN_MS,
  parameter int HOLD_MS = `PFR_HOLD_MS,
  parameter int AC_DELAY_MS = `PFR_AC_DELAY_MS,
  parameter int STBY_LEAD_MS = `PFR_STBY_LEAD_MS,
  parameter int HICCUP_MS = `PFR_HICCUP_MS,
  parameter int BLINK_MS = `PFR_BLINK_MS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic enable_pin,
  input wire logic slot_interlock_pin,
  input wire logic ac_ok_pin,
  input wire logic limit_pin,
  input wire logic ov_pin,
  input wire logic ot_pin,
  input wire logic two_wire_pin,
  input wire logic [15:0] vout_meas,
  input wire logic [15:0] vin_meas,
  input wire logic [15:0] vprog_meas,
  output logic main_on,
  output logic [15:0] vout_setpoint,
  output logic standby_rail,
  output logic output_fail_warning,
  output logic output_led,
  output logic input_led
);
  if (GRACE_MS > 65535 || OC_DELAY_MS > 65535 || RETRY_MS > 65535 ||
      OV_WIN_MS > 65535 || HOLD_MS > 65535 || AC_DELAY_MS > 65535 ||
      STBY_LEAD_MS > 65535 || HICCUP_MS > 65535 || BLINK_MS < 1 ||
      BLINK_MS > 65535) begin : g_bad
    $error("pfr_top: millisecond count out of range");
  end
  // ----------------------------------------------------------------
  // time base and pin conditioning
  // ----------------------------------------------------------------
  pfr_tick_if tk_if ();
  logic tick;
  logic [6:0] pin_s;
  logic en_s, ilk_s, ac_s, oc_s, ov_s, ot_s, tw_s;
  pfr_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .mclk(mclk),
    .nrst(nrst),
    .tk(tk_if.src)
  );
  assign tick = tk_if.tick;
  pfr_pin_filter #(.N(7), .FILT(`PFR_FILT_CYC)) u_pins (
    .mclk(mclk),
    .nrst(nrst),
    .pin_raw({two_wire_pin, ot_pin, ov_pin, limit_pin, ac_ok_pin,
              slot_interlock_pin, enable_pin}),
    .pin_clean(pin_s)
  );
  assign {tw_s, ot_s, ov_s, oc_s, ac_s, ilk_s, en_s} = pin_s;
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  pfr_state_e state_reg, state_next;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic op_on_reg;
  logic [1:0] fcfg_reg;
  logic fw_taken_reg;
  pfr_volt_t fw_sp_reg;
  pfr_volt_t sp_next;
  pfr_alarm_t alarm_reg, alarm_set;
  logic restart_ok_reg;
  logic lat_ov_reg;
  pfr_ms_t st_ms_reg, ac_ms_reg, oc_ms_reg, win_ms_reg, blink_ms_reg;
  logic [1:0] ov_cnt_reg;
  logic blink_reg;
  logic req, wr_fire, rd_take;
  logic want_on, off_req, start_ok, grace_done, win_exp, ov_last, restart;
  logic ev_ov, ev_ot, ev_oc, ev_short, ev_ilk;
  logic [31:0] rd_mux;
  logic [19:0] vprog_scaled;
  // ----------------------------------------------------------------
  // avalon slave: one wait state on every access
  // ----------------------------------------------------------------
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_fire = avs_write & ack_reg & avs_byteenable[0];
  assign rd_take = avs_read & ~ack_reg;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `PFR_OFS_OPERATION: rd_mux = {31'h0, op_on_reg};
      `PFR_OFS_FAULT_CFG: rd_mux = {30'h0, fcfg_reg};
      `PFR_OFS_STATUS: rd_mux = {18'h0, ov_cnt_reg, fw_taken_reg,
                                 tw_s, ot_s, ov_s, oc_s, ac_s, ilk_s, en_s,
                                 1'b0, state_reg};
      `PFR_OFS_ALARM: rd_mux = {27'h0, alarm_reg};
      `PFR_OFS_STATUS2: rd_mux = {31'h0, restart_ok_reg};
      `PFR_OFS_SETPOINT: rd_mux = {16'h0, vout_setpoint};
      `PFR_OFS_VOUT_CMD: rd_mux = {16'h0, fw_sp_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_reg <= rd_mux;
    end
  end
  assign avs_readdata = rdata_reg;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      op_on_reg <= `PFR_RST_OP_ON;
      fcfg_reg <= `PFR_RST_FCFG;
    end else if (wr_fire && avs_address == `PFR_OFS_OPERATION) begin
      op_on_reg <= avs_writedata[0];
    end else if (wr_fire && avs_address == `PFR_OFS_FAULT_CFG) begin
      fcfg_reg <= avs_writedata[1:0];
    end
  end
  // ----------------------------------------------------------------
  // setpoint arbitration
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fw_taken_reg <= 1'b0;
      fw_sp_reg <= `PFR_V_DEFAULT;
    end else if (wr_fire && avs_address == `PFR_OFS_VOUT_CMD &&
                 avs_byteenable[1]) begin
      fw_taken_reg <= 1'b1;
      fw_sp_reg <= avs_writedata[15:0];
    end
  end
  assign vprog_scaled = ({4'h0, vprog_meas} * `PFR_VPROG_NUM) / `PFR_VPROG_DEN;
  always_comb begin
    if (fw_taken_reg) begin
      sp_next = fw_sp_reg;
    end else if (vprog_meas < `PFR_VPROG_MIN) begin
      sp_next = `PFR_V_DEFAULT;
    end else if (vprog_scaled > {4'h0, `PFR_V_MAX}) begin
      sp_next = `PFR_V_MAX;
    end else if (vprog_scaled < {4'h0, `PFR_V_DEFAULT}) begin
      sp_next = `PFR_V_DEFAULT;
    end else begin
      sp_next = vprog_scaled[15:0];
    end
  end
  // ----------------------------------------------------------------
  // supervisor state machine
  // ----------------------------------------------------------------
  assign want_on = en_s & op_on_reg & ac_s & ilk_s;
  assign off_req = ~want_on;
  assign start_ok = ac_ms_reg >= (tw_s ? 16'(AC_DELAY_MS) : 16'(STBY_LEAD_MS));
  assign grace_done = st_ms_reg >= 16'(GRACE_MS);
  assign win_exp = (ov_cnt_reg != 2'h0) && (win_ms_reg >= 16'(OV_WIN_MS));
  assign ov_last = (ov_cnt_reg == (`PFR_OV_TRIES - 2'h1)) && !win_exp;
  always_comb begin
    state_next = state_reg;
    restart = 1'b0;
    ev_ov = 1'b0;
    ev_ot = 1'b0;
    ev_oc = 1'b0;
    ev_short = 1'b0;
    ev_ilk = 1'b0;
    case (state_reg)
      ST_OFF: begin
        if (want_on && start_ok) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!want_on) begin
          state_next = ST_OFF;
          ev_ilk = ~ilk_s;
        end else if (ov_s) begin
          ev_ov = 1'b1;
          state_next = ov_last ? ST_LATCH : ST_RETRY;
        end else if (ot_s) begin
          ev_ot = 1'b1;
          state_next = fcfg_reg[`PFR_CFG_OT] ? ST_LATCH : ST_RETRY;
        end else if (oc_s && vout_meas < `PFR_V_SHORT) begin
          ev_short = 1'b1;
          state_next = fcfg_reg[`PFR_CFG_OC] ? ST_LATCH : ST_RETRY;
        end else if (oc_s && oc_ms_reg >= 16'(OC_DELAY_MS)) begin
          ev_oc = 1'b1;
          state_next = fcfg_reg[`PFR_CFG_OC] ? ST_LATCH : ST_RETRY;
        end else if (oc_s && grace_done && vout_meas < `PFR_V_DEFAULT &&
                     !fcfg_reg[`PFR_CFG_OC]) begin
          state_next = ST_HICCUP;
        end
      end
      ST_RETRY: begin
        if (st_ms_reg >= 16'(RETRY_MS) && !ov_s && !ot_s) begin
          state_next = ST_OFF;
        end
      end
      ST_HICCUP: begin
        if (st_ms_reg >= 16'(HICCUP_MS)) begin
          state_next = ST_OFF;
        end
      end
      ST_LATCH: begin
        if (!lat_ov_reg && fcfg_reg == 2'h0) begin
          state_next = ST_OFF;
          restart = 1'b1;
        end else if (off_req) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!off_req) begin
          if (st_ms_reg >= 16'(HOLD_MS)) begin
            state_next = ST_OFF;
            restart = 1'b1;
          end else begin
            state_next = ST_LATCH;
          end
        end
      end
      default: state_next = ST_OFF;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lat_ov_reg <= 1'b0;
    end else if (state_reg == ST_RUN && state_next == ST_LATCH) begin
      lat_ov_reg <= ev_ov;
    end
  end
  // ----------------------------------------------------------------
  // millisecond counters; st, ac and oc saturate, the window and blink counters restart from zero
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst || state_next != state_reg) begin
      st_ms_reg <= 16'h0000;
    end else if (tick && st_ms_reg != 16'hffff) begin
      st_ms_reg <= st_ms_reg + 16'h0001;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst || !ac_s) begin
      ac_ms_reg <= 16'h0000;
    end else if (tick && ac_ms_reg != 16'hffff) begin
      ac_ms_reg <= ac_ms_reg + 16'h0001;
    end
  end
  // overcurrent time only counts once the startup grace is over
  always_ff @(posedge mclk) begin
    if (!nrst || state_reg != ST_RUN || !oc_s || !grace_done) begin
      oc_ms_reg <= 16'h0000;
    end else if (tick && oc_ms_reg != 16'hffff) begin
      oc_ms_reg <= oc_ms_reg + 16'h0001;
    end
  end
  // a shutdown landing on window expiry opens a fresh window at one
  always_ff @(posedge mclk) begin
    if (!nrst || restart) begin
      ov_cnt_reg <= 2'h0;
    end else if (ev_ov) begin
      ov_cnt_reg <= win_exp ? 2'h1 : ov_cnt_reg + 2'h1;
    end else if (win_exp) begin
      ov_cnt_reg <= 2'h0;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst || restart || ov_cnt_reg == 2'h0 || win_exp) begin
      win_ms_reg <= 16'h0000;
    end else if (tick) begin
      win_ms_reg <= win_ms_reg + 16'h0001;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      blink_ms_reg <= 16'h0000;
      blink_reg <= 1'b0;
    end else if (tick && blink_ms_reg == 16'(BLINK_MS - 1)) begin
      blink_ms_reg <= 16'h0000;
      blink_reg <= ~blink_reg;
    end else if (tick) begin
      blink_ms_reg <= blink_ms_reg + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // alarms and restart flag; a new event beats any clear
  // ----------------------------------------------------------------
  always_comb begin
    alarm_set = '0;
    alarm_set[`PFR_ALM_OC] = ev_oc;
    alarm_set[`PFR_ALM_OT] = ev_ot;
    alarm_set[`PFR_ALM_OV] = ev_ov;
    alarm_set[`PFR_ALM_SHORT] = ev_short;
    alarm_set[`PFR_ALM_ILK] = ev_ilk;
  end
  always_ff @(posedge mclk) begin
    if (!nrst || restart) begin
      alarm_reg <= '0;
    end else if (wr_fire && avs_address == `PFR_OFS_ALARM) begin
      alarm_reg <= (alarm_reg & ~avs_writedata[4:0]) | alarm_set;
    end else begin
      alarm_reg <= alarm_reg | alarm_set;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      restart_ok_reg <= 1'b0;
    end else if (restart) begin
      restart_ok_reg <= 1'b1;
    end else if (wr_fire && avs_address == `PFR_OFS_STATUS2 &&
                 avs_writedata[`PFR_ST2_RESTART]) begin
      restart_ok_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      main_on <= 1'b0;
      vout_setpoint <= `PFR_V_DEFAULT;
      standby_rail <= 1'b0;
      output_fail_warning <= 1'b1;
      output_led <= 1'b0;
      input_led <= 1'b0;
    end else begin
      main_on <= state_next == ST_RUN;
      vout_setpoint <= sp_next;
      standby_rail <= ac_s;
      output_fail_warning <= ~ac_s | (state_next != ST_RUN);
      if (state_next == ST_RUN && oc_s && vout_meas > `PFR_V_BLINK) begin
        output_led <= blink_reg;
      end else begin
        output_led <= state_next == ST_RUN;
      end
      input_led <= (vin_meas < `PFR_VIN_LOW) ? blink_reg : ac_s;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  fw_lock_a: assert property (fw_taken_reg |=> vout_setpoint == $past(fw_sp_reg))
    else $error("firmware setpoint not held");
  sp_default_a: assert property (!fw_taken_reg && vprog_meas < `PFR_VPROG_MIN
      |=> vout_setpoint == `PFR_V_DEFAULT)
    else $error("default setpoint not applied");
  ilk_off_a: assert property (state_reg == ST_RUN && !ilk_s |=> !main_on)
    else $error("output still on without interlock");
  short_stop_a: assert property (state_reg == ST_RUN && want_on && !ov_s && !ot_s &&
      oc_s && vout_meas < `PFR_V_SHORT |=> !main_on ##0 alarm_reg[`PFR_ALM_SHORT])
    else $error("short circuit did not stop output");
  grace_hold_a: assert property (state_reg == ST_RUN && want_on && !ov_s && !ot_s &&
      st_ms_reg < 16'(GRACE_MS) && vout_meas >= `PFR_V_SHORT |=> main_on)
    else $error("output dropped during startup grace");
  oc_early_a: assert property (state_reg == ST_RUN && oc_ms_reg < 16'(OC_DELAY_MS) &&
      want_on && !ov_s && !ot_s && vout_meas >= `PFR_V_DEFAULT && grace_done
      |=> state_reg == ST_RUN)
    else $error("overcurrent shutdown too early");
  hold_short_a: assert property (state_reg == ST_HOLD && !off_req &&
      st_ms_reg < 16'(HOLD_MS) |=> state_reg == ST_LATCH ##1 !main_on)
    else $error("restart after less than hold time");
  restart_flag_a: assert property (restart |=> restart_ok_reg && alarm_reg == '0
      && ov_cnt_reg == 2'h0)
    else $error("restart did not clear alarms or set flag");
  ov_latch_a: assert property (state_reg == ST_RUN && want_on && ov_s && ov_last
      |=> state_reg == ST_LATCH ##1 !output_led)
    else $error("third overvoltage did not latch");
  ov_window_a: assert property (win_exp && !ev_ov |=> ov_cnt_reg == 2'h0)
    else $error("overvoltage count kept past window");
  ac_wait_a: assert property (state_reg == ST_OFF && tw_s &&
      ac_ms_reg < 16'(AC_DELAY_MS) |=> !main_on)
    else $error("two-wire start before ac delay");
  stby_first_a: assert property ($rose(main_on) |-> standby_rail &&
      ac_ms_reg >= 16'(STBY_LEAD_MS))
    else $error("main output before standby lead");
  warn_ac_a: assert property (!ac_s |=> output_fail_warning)
    else $error("no warning on input failure");
  cov_hold_c: cover property (state_reg == ST_HOLD ##1 restart);
  cov_hiccup_c: cover property (state_reg == ST_RUN ##1 state_reg == ST_HICCUP);
  cov_ov_latch_c: cover property (ev_ov && ov_last);
  cov_reconfig_c: cover property (state_reg == ST_LATCH && restart);
endmodule // pfr_top
`default_nettype wire

//--- pfr_host.sv
`timescale 1ns/1ps
`default_nettype none
module pfr_host (
  input wire logic mclk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
  // request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // idle edge so a strobe never drops and rises in one step
    @(posedge mclk);
  endtask
endmodule // pfr_host
`default_nettype wire

//--- pfr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pfr_tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic avs_read, avs_write, avs_waitrequest, enable_pin, main_on, standby_rail;
  logic slot_interlock_pin, ac_ok_pin, limit_pin, ov_pin, ot_pin, two_wire_pin, lv;
  logic output_fail_warning, output_led, input_led;
  logic [3:0] avs_byteenable;
  logic [15:0] vin_meas;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] vout_meas, vprog_meas, vout_setpoint;
  int fail_count = 0;
  int n_checks = 0;
  always #12.5 mclk = ~mclk;
  // a 10-cycle millisecond keeps every count short
  localparam int TB_TICK = 10, TB_GRACE = 20, TB_OC = 5, TB_RETRY = 3, TB_WIN = 60;
  localparam int TB_HOLD = 4, TB_AC = 10, TB_STBY = 3, TB_HICCUP = 3, TB_BLINK = 2;
  pfr_top #(.TICK_CYC(TB_TICK), .GRACE_MS(TB_GRACE), .OC_DELAY_MS(TB_OC),
    .RETRY_MS(TB_RETRY), .OV_WIN_MS(TB_WIN), .HOLD_MS(TB_HOLD), .AC_DELAY_MS(TB_AC),
    .STBY_LEAD_MS(TB_STBY), .HICCUP_MS(TB_HICCUP), .BLINK_MS(TB_BLINK)) pfr_top_i (
    .mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .enable_pin, .slot_interlock_pin, .ac_ok_pin, .limit_pin,
    .ov_pin, .ot_pin, .two_wire_pin, .vout_meas, .vin_meas, .vprog_meas,
    .main_on, .vout_setpoint, .standby_rail, .output_fail_warning, .output_led, .input_led);
  pfr_host pfr_host_i (.mclk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
    .avs_write, .avs_writedata);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    fail_count += int'(s !== e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    pfr_host_i.acc(1'b0, a, 32'h0, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    pfr_host_i.acc(1'b1, a, d, q);
  endtask
  task automatic won(input logic v, input int n);
    while (main_on !== v && n-- > 0)
      @(posedge mclk);
    chk(main_on, v);
  endtask
  task automatic close_out;
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    idle(6000);
    fail_count++;
    close_out;
  end
  initial begin
    {slot_interlock_pin, ac_ok_pin, enable_pin} = 3'h7;
    {limit_pin, ov_pin} = 2'h0;
    {ot_pin, two_wire_pin} = 2'h1;
    avs_byteenable = 4'hf;
    vin_meas = 16'h2ee0;
    vout_meas = 16'h1000;
    vprog_meas = 16'h0032;
    idle(8);
    chk(vout_setpoint, 16'h08fc);
    nrst <= 1'b1;
    rdc(8'h10, 32'h0);
    wr(8'h08, 32'h1);
    // two-wire mode: the short standby lead alone must not start it
    idle(50);
    chk(main_on, 1'b0);
    won(1'b1, 200);
    chk(standby_rail, 1'b1);
    chk(output_led, 1'b1);
    chk(output_fail_warning, 1'b0);
    chk(input_led, 1'b1);
    limit_pin <= 1'b1;
    idle(130);
    lv = output_led;
    idle(20);
    chk(output_led ^ lv, 1'b1);
    chk(main_on, 1'b1);
    won(1'b0, 200);
    rd(8'h40);
    chk(q[2:0], 3'h4);
    limit_pin <= 1'b0;
    // back to auto-restart frees the latch at once
    wr(8'h08, 32'h0);
    won(1'b1, 100);
    rdc(8'h48, 32'h1);
    wr(8'h48, 32'h1);
    rdc(8'h48, 32'h0);
    // a write without its low byte enabled is ignored
    avs_byteenable <= 4'he;
    wr(8'h04, 32'h0);
    avs_byteenable <= 4'hf;
    rdc(8'h04, 32'h1);
    vprog_meas <= 16'h0bb8;
    idle(4);
    chk(vout_setpoint, 16'h1964);
    wr(8'h84, 32'h1000);
    vprog_meas <= 16'h0032;
    idle(4);
    chk(vout_setpoint, 16'h1000);
    vout_meas <= 16'h0100;
    limit_pin <= 1'b1;
    won(1'b0, 12);
    limit_pin <= 1'b0;
    vout_meas <= 16'h1000;
    rdc(8'h44, 32'h8);
    wr(8'h44, 32'h8);
    rdc(8'h44, 32'h0);
    won(1'b1, 100);
    vout_meas <= 16'h0400;
    limit_pin <= 1'b1;
    won(1'b0, 300);
    rd(8'h40);
    chk(q[2:0], 3'h3);
    limit_pin <= 1'b0;
    vout_meas <= 16'h1000;
    won(1'b1, 100);
    ot_pin <= 1'b1;
    won(1'b0, 12);
    idle(60);
    chk(main_on, 1'b0);
    ot_pin <= 1'b0;
    rdc(8'h44, 32'h2);
    for (int i = 0; i < 5; i++) begin
      won(1'b1, 300);
      idle(i == 2 ? 700 : 0);
      ov_pin <= 1'b1;
      idle(10);
      ov_pin <= 1'b0;
    end
    vin_meas <= 16'h1000;
    idle(2);
    lv = input_led;
    idle(20);
    chk(input_led ^ lv, 1'b1);
    vin_meas <= 16'h2ee0;
    idle(38);
    rd(8'h40);
    chk(q[2:0], 3'h4);
    chk(output_led, 1'b0);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h1);
    idle(60);
    chk(main_on, 1'b0);
    enable_pin <= 1'b0;
    idle(60);
    enable_pin <= 1'b1;
    won(1'b1, 100);
    rd(8'h40);
    chk(q[13:12], 2'h0);
    rdc(8'h48, 32'h1);
    // latch on over-temperature, then a slow operation off and on
    wr(8'h08, 32'h2);
    ot_pin <= 1'b1;
    won(1'b0, 12);
    ot_pin <= 1'b0;
    idle(40);
    rd(8'h40);
    chk(q[2:0], 3'h4);
    wr(8'h04, 32'h0);
    idle(250);
    wr(8'h04, 32'h1);
    won(1'b1, 20);
    ac_ok_pin <= 1'b0;
    won(1'b0, 12);
    chk(output_fail_warning, 1'b1);
    chk(standby_rail, 1'b0);
    ac_ok_pin <= 1'b1;
    won(1'b1, 200);
    slot_interlock_pin <= 1'b0;
    won(1'b0, 12);
    rdc(8'h44, 32'h10);
    close_out;
  end
endmodule // pfr_tb_top
`default_nettype wire
